// ---- inc/burst_wrap_pkg.sv ----
/*
  Constants, types and helpers for the read burst wrap addressing block.
  Assumes a 10 MHz system clock and a 24-bit serial start address.
*/
`default_nettype none
package burst_wrap_pkg;
  localparam int ADDR_W   = 24;
  localparam int BYTE_W   = 8;
  localparam int MEM_WORDS = 64;
  localparam int BUF_DEPTH = 2;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CFG_NV    = 8'h00;
  localparam logic [7:0] OFS_CFG_V     = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_MEM_INDEX = 8'h0c;
  localparam logic [7:0] OFS_MEM_DATA  = 8'h10;
  localparam logic [7:0] OFS_LAST_ADDR = 8'h14;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BIT_WRAP_EN   = 4;
  localparam int BIT_PD_AT_PON = 2;
  localparam int WL_MSB        = 1;
  localparam int WL_LSB        = 0;
  localparam int STAT_DPD_BIT  = 0;
  localparam int STAT_DATA_BIT = 1;
  localparam logic [7:0] CFG_NV_RESET = 8'h08;
  localparam logic [7:0] CFG_V_WMASK  = 8'hfb;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] SYNC_RESET   = 3'b010;

  typedef enum logic [1:0] {
    WRAP_8  = 2'b00,
    WRAP_16 = 2'b01,
    WRAP_32 = 2'b10,
    WRAP_64 = 2'b11
  } wrap_length_type;

  typedef enum {PWR_POR, PWR_STANDBY, PWR_DPD} power_state_type;
  typedef enum {LNK_IDLE, LNK_ADDR, LNK_DATA} link_state_type;

  // Mask of the address bits that move inside a wrap group
  function automatic logic [ADDR_W-1:0] wrap_mask(input logic [1:0] sel);
    case (sel)
      WRAP_8:  wrap_mask = 24'h000007;
      WRAP_16: wrap_mask = 24'h00000f;
      WRAP_32: wrap_mask = 24'h00001f;
      default: wrap_mask = 24'h00003f;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] next_burst_addr(input logic [ADDR_W-1:0] a,
                                                        input logic              wen,
                                                        input logic [1:0]        sel);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    m   = wrap_mask(sel);
    inc = a + 24'h000001;
    if (wen)
      next_burst_addr = (a & ~m) | (inc & m);
    else
      next_burst_addr = inc;
  endfunction
endpackage
`default_nettype wire

// ---- inc/byte_buf_if.sv ----
/*
  Carrier between the address sequencer and its two-entry byte buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface byte_buf_if;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;
  logic       flush;

  modport fill  (output in_valid, in_data, out_ready, flush,
                 input  in_ready, out_valid, out_data);
  modport store (input  in_valid, in_data, out_ready, flush,
                 output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ---- logic/byte_buf.sv ----
/*
  Two-entry byte buffer between the fetch side and the serial shifter.
  Assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_buf
(
  input  wire logic  mclk_i,
  input  wire logic  reset_n_i,
  input  wire logic  ce_i,
  byte_buf_if.store  bus
);
  import burst_wrap_pkg::*;

  logic [7:0] data0_reg;
  logic [7:0] data1_reg;
  logic [1:0] cnt_reg;
  logic [7:0] data0_next;
  logic [7:0] data1_next;
  logic [1:0] cnt_next;
  logic       push;
  logic       pop;

  assign bus.in_ready  = (cnt_reg != 2'(BUF_DEPTH));
  assign bus.out_valid = (cnt_reg != 2'h0);
  assign bus.out_data  = data0_reg;
  assign push = bus.in_valid & bus.in_ready;
  assign pop  = bus.out_ready & bus.out_valid;

  always_comb
  begin
    data0_next = data0_reg;
    data1_next = data1_reg;
    cnt_next   = cnt_reg;
    if (bus.flush)
      cnt_next = 2'h0;
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (cnt_reg == 2'h0)
            data0_next = bus.in_data;
          else
            data1_next = bus.in_data;
          cnt_next = cnt_reg + 2'h1;
        end
        2'b01:
        begin
          data0_next = data1_reg;
          cnt_next   = cnt_reg - 2'h1;
        end
        2'b11:
        begin
          // Count one means the new byte moves straight to the head
          data0_next = (cnt_reg == 2'h1) ? bus.in_data : data1_reg;
          data1_next = bus.in_data;
        end
        default:
          cnt_next = cnt_reg;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      data0_reg <= 8'h00;
      data1_reg <= 8'h00;
      cnt_reg   <= 2'h0;
    end
    else if (ce_i)
    begin
      data0_reg <= data0_next;
      data1_reg <= data1_next;
      cnt_reg   <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// ---- logic/read_burst_wrap_addressing.sv ----
/*
  Read burst address sequencer of a serial flash, with its configuration
  registers on an AHB-Lite slave and a 256-byte data array behind it.
  Assumes the host drives sclk, cs_n and si from another clock domain;
  all three are sampled by mclk_i, which must be much faster than sclk.
*/
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
//
// Operation
// - After reset completes the device enters standby if powerdown_at_poweron is 0, else deep power-down.
// - A set powerdown_at_poweron makes deep power-down the state after the one-cycle PWR_POR step that follows reset.
// - The two-bit wrap_length_sel sets both wrap length and group alignment.
// - wrap_length_sel 00, 01, 10, 11 mean 8, 16, 32, 64 bytes.
// - wrap_length_sel lives in both configuration copies, read-write, reset 00.
// - With wrapping off the address steps by one per byte across group edges.
// - 8-byte wrap moves only the low three address bits.
// - 16-byte wrap moves the low four address bits modulo 16.
// - 32-byte wrap moves the low five address bits modulo 32.
// - 64-byte wrap moves the low six address bits modulo 64.
// - Wrapping happens only with wrap_enable at 1; at 0 reads are sequential.
// - The wrap length used is the one held in the volatile wrap_length_sel.
`timescale 1ns/1ps
`default_nettype none
module read_burst_wrap_addressing
(
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        ce_i,
  input  wire logic                        sclk_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        si_i,
  output logic                             so_o,
  output logic                             so_oe_n_o,
  output logic                             deep_powerdown_o,
  input  wire logic                        hsel_i,
  input  wire logic [31:0]                 haddr_i,
  input  wire logic [1:0]                  htrans_i,
  input  wire logic                        hwrite_i,
  input  wire logic [2:0]                  hsize_i,
  input  wire logic [31:0]                 hwdata_i,
  input  wire logic                        hready_i,
  output logic [31:0]                      hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  output logic [burst_wrap_pkg::ADDR_W-1:0] last_addr_o
);
  import burst_wrap_pkg::*;

  // ****************************************
  // Pin synchronisers {sclk, cs_n, si}
  // ****************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_fall;

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      prev_reg  <= SYNC_RESET;
    end
    else if (ce_i)
    begin
      sync1_reg <= {sclk_i, cs_n_i, si_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign sclk_rise = sync2_reg[2] & ~prev_reg[2];
  assign sclk_fall = ~sync2_reg[2] & prev_reg[2];
  assign cs_rise   = sync2_reg[1] & ~prev_reg[1];
  assign cs_fall   = ~sync2_reg[1] & prev_reg[1];

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  logic        ap_valid_reg;
  logic        ap_write_reg;
  logic [7:0]  ap_addr_reg;
  logic [31:0] hrdata_reg;
  logic        ap_valid_next;
  logic        ap_write_next;
  logic [7:0]  ap_addr_next;
  logic [31:0] hrdata_next;
  logic        take;
  logic        wr_hit;
  logic [31:0] rd_mux;

  // Nonvolatile copy takes its default at power-up only, so a reset keeps it
  logic [7:0]        cfg_nv_reg = CFG_NV_RESET;
  logic [7:0]        cfg_v_reg;
  logic [5:0]        mem_index_reg;
  logic [ADDR_W-1:0] last_addr_reg;
  power_state_type   pwr_reg;
  link_state_type    lnk_reg;
  logic [31:0]       mem [MEM_WORDS];

  assign take   = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
  assign wr_hit = ap_valid_reg & ap_write_reg;

  // Unmapped offsets read as zero and still answer OKAY
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (haddr_i[7:0])
      OFS_CFG_NV:    rd_mux = {24'h000000, cfg_nv_reg};
      OFS_CFG_V:     rd_mux = {24'h000000, cfg_v_reg};
      OFS_STATUS:    rd_mux = {30'h00000000, lnk_reg == LNK_DATA, pwr_reg == PWR_DPD};
      OFS_MEM_INDEX: rd_mux = {26'h0000000, mem_index_reg};
      OFS_MEM_DATA:  rd_mux = mem[mem_index_reg];
      OFS_LAST_ADDR: rd_mux = {8'h00, last_addr_reg};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_comb
  begin
    ap_valid_next = take;
    ap_write_next = take ? hwrite_i : ap_write_reg;
    ap_addr_next  = take ? haddr_i[7:0] : ap_addr_reg;
    hrdata_next   = (take & ~hwrite_i) ? rd_mux : hrdata_reg;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 8'h00;
      hrdata_reg   <= 32'h00000000;
    end
    else if (ce_i)
    begin
      ap_valid_reg <= ap_valid_next;
      ap_write_reg <= ap_write_next;
      ap_addr_reg  <= ap_addr_next;
      hrdata_reg   <= hrdata_next;
    end
  end

  assign hrdata_o    = hrdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************
  // Configuration, power state, data array
  // ****************************************
  logic [7:0]      cfg_nv_next;
  logic [7:0]      cfg_v_next;
  logic [5:0]      mem_index_next;
  power_state_type pwr_next;
  logic            mem_we;

  always_comb
  begin
    cfg_nv_next    = cfg_nv_reg;
    cfg_v_next     = cfg_v_reg;
    mem_index_next = mem_index_reg;
    pwr_next       = pwr_reg;
    mem_we         = 1'b0;
    if (wr_hit)
    begin
      case (ap_addr_reg)
        OFS_CFG_NV:    cfg_nv_next = hwdata_i[7:0];
        OFS_CFG_V:     cfg_v_next = (hwdata_i[7:0] & CFG_V_WMASK) | (cfg_v_reg & ~CFG_V_WMASK);
        OFS_MEM_INDEX: mem_index_next = hwdata_i[5:0];
        OFS_MEM_DATA:  mem_we = 1'b1;
        default:       mem_we = 1'b0;
      endcase
    end
    case (pwr_reg)
      PWR_POR:
      begin
        // Volatile copy is loaded from the nonvolatile one on the way out of reset
        cfg_v_next = cfg_nv_reg;
        if (cfg_nv_reg[BIT_PD_AT_PON])
          pwr_next = PWR_DPD;
        else
          pwr_next = PWR_STANDBY;
      end
      PWR_DPD:
      begin
        // a chip select pulse wakes the device
        if (cs_rise)
          pwr_next = PWR_STANDBY;
      end
      PWR_STANDBY:
        pwr_next = PWR_STANDBY;
      default:
        pwr_next = PWR_POR;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      // wrap length resets to 8 bytes
      cfg_v_reg     <= CFG_NV_RESET;
      mem_index_reg <= 6'h00;
      pwr_reg       <= PWR_POR;
    end
    else if (ce_i)
    begin
      cfg_nv_reg    <= cfg_nv_next;
      cfg_v_reg     <= cfg_v_next;
      mem_index_reg <= mem_index_next;
      pwr_reg       <= pwr_next;
    end
  end

  // Array contents are not reset; software loads them before reading
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && mem_we)
      mem[mem_index_reg] <= hwdata_i;
  end

  assign deep_powerdown_o = (pwr_reg == PWR_DPD);

  // ****************************************
  // Serial link: address in, bursts out
  // ****************************************
  byte_buf_if bq ();

  logic [ADDR_W-1:0] shift_addr_reg;
  logic [4:0]        bit_cnt_reg;
  logic [ADDR_W-1:0] gen_addr_reg;
  logic [7:0]        out_sh_reg;
  logic [2:0]        out_bits_reg;
  logic              so_reg;
  logic              oe_n_reg;
  link_state_type    lnk_next;
  logic [ADDR_W-1:0] shift_addr_next;
  logic [4:0]        bit_cnt_next;
  logic [ADDR_W-1:0] gen_addr_next;
  logic [7:0]        out_sh_next;
  logic [2:0]        out_bits_next;
  logic              so_next;
  logic              oe_n_next;
  logic [ADDR_W-1:0] last_addr_next;
  logic [31:0]       fetch_word;
  logic              wrap_en;
  logic [1:0]        wrap_sel;

  assign wrap_en    = cfg_v_reg[BIT_WRAP_EN];
  assign wrap_sel   = cfg_v_reg[WL_MSB:WL_LSB];
  assign fetch_word = mem[gen_addr_reg[7:2]];
  assign bq.in_data = 8'(fetch_word >> {gen_addr_reg[1:0], 3'b000});

  always_comb
  begin
    lnk_next        = lnk_reg;
    shift_addr_next = shift_addr_reg;
    bit_cnt_next    = bit_cnt_reg;
    gen_addr_next   = gen_addr_reg;
    out_sh_next     = out_sh_reg;
    out_bits_next   = out_bits_reg;
    so_next         = so_reg;
    oe_n_next       = oe_n_reg;
    last_addr_next  = last_addr_reg;
    bq.in_valid     = 1'b0;
    bq.out_ready    = 1'b0;
    bq.flush        = 1'b0;
    case (lnk_reg)
      LNK_IDLE:
      begin
        // Deep power-down ignores frames
        if (cs_fall && pwr_reg == PWR_STANDBY)
        begin
          lnk_next     = LNK_ADDR;
          bit_cnt_next = 5'h00;
        end
      end
      LNK_ADDR:
      begin
        if (cs_rise)
          lnk_next = LNK_IDLE;
        else if (sclk_rise)
        begin
          shift_addr_next = {shift_addr_reg[ADDR_W-2:0], sync2_reg[0]};
          bit_cnt_next    = bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'(ADDR_W - 1))
          begin
            // burst starts at the exact start address
            gen_addr_next = {shift_addr_reg[ADDR_W-2:0], sync2_reg[0]};
            out_bits_next = 3'h0;
            lnk_next      = LNK_DATA;
          end
        end
      end
      LNK_DATA:
      begin
        if (cs_rise)
        begin
          // burst runs until chip select rises
          lnk_next  = LNK_IDLE;
          oe_n_next = 1'b1;
          bq.flush  = 1'b1;
        end
        else
        begin
          // Fetch stalls while both buffer entries are full
          bq.in_valid = 1'b1;
          if (bq.in_ready)
          begin
            last_addr_next = gen_addr_reg;
            // sequential step when wrapping is off
            // low three bits in 8-byte mode
            // low four bits in 16-byte mode
            // low five bits in 32-byte mode
            // low six bits in 64-byte mode
            // upper bits held by the mask
            gen_addr_next = next_burst_addr(gen_addr_reg, wrap_en, wrap_sel);
          end
          if (sclk_fall)
          begin
            if (out_bits_reg == 3'h0)
            begin
              // An empty buffer repeats the last bit rather than stall the host
              if (bq.out_valid)
              begin
                bq.out_ready  = 1'b1;
                so_next       = bq.out_data[7];
                out_sh_next   = {bq.out_data[6:0], 1'b0};
                out_bits_next = 3'h7;
                oe_n_next     = 1'b0;
              end
            end
            else
            begin
              so_next       = out_sh_reg[7];
              out_sh_next   = {out_sh_reg[6:0], 1'b0};
              out_bits_next = out_bits_reg - 3'h1;
            end
          end
        end
      end
      default:
        lnk_next = LNK_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      lnk_reg        <= LNK_IDLE;
      shift_addr_reg <= 24'h000000;
      bit_cnt_reg    <= 5'h00;
      gen_addr_reg   <= 24'h000000;
      out_sh_reg     <= 8'h00;
      out_bits_reg   <= 3'h0;
      so_reg         <= 1'b0;
      oe_n_reg       <= 1'b1;
      last_addr_reg  <= 24'h000000;
    end
    else if (ce_i)
    begin
      lnk_reg        <= lnk_next;
      shift_addr_reg <= shift_addr_next;
      bit_cnt_reg    <= bit_cnt_next;
      gen_addr_reg   <= gen_addr_next;
      out_sh_reg     <= out_sh_next;
      out_bits_reg   <= out_bits_next;
      so_reg         <= so_next;
      oe_n_reg       <= oe_n_next;
      last_addr_reg  <= last_addr_next;
    end
  end

  byte_buf u_buf
  (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .bus       (bq.store)
  );

  assign so_o        = so_reg;
  assign so_oe_n_o   = oe_n_reg;
  assign last_addr_o = last_addr_reg;
endmodule
`default_nettype wire

// ---- tb/burst_wrap_chk.sv ----
/*
  Port checker for the read burst wrap block, bound to its top module.
  Assumes one 10 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_wrap_chk
(
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        so_o,
  input wire logic        so_oe_n_o,
  input wire logic        deep_powerdown_o,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // ****
  // Helper counters, saturating
  // ****
  logic       sclk_reg;
  logic       cs_reg;
  logic [3:0] fall_reg;
  logic [3:0] fall_next;
  logic [7:0] low_reg;
  logic [7:0] low_next;
  logic [3:0] rise_reg;
  logic [3:0] rise_next;
  logic [3:0] rst_reg;
  logic [3:0] rst_next;
  always_comb
  begin
    fall_next = (sclk_reg && !sclk_i) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hf};
    low_next  = cs_n_i ? 8'h00 : low_reg + {7'h00, low_reg != 8'hff};
    rise_next = (!cs_reg && cs_n_i) ? 4'h0 : rise_reg + {3'h0, rise_reg != 4'hf};
    rst_next  = rst_reg + {3'h0, rst_reg != 4'hf};
  end
  always_ff @(posedge mclk_i)
  begin
    sclk_reg <= sclk_i;
    cs_reg   <= cs_n_i;
    if (!reset_n_i)
    begin
      fall_reg <= 4'hf;
      low_reg  <= 8'h00;
      rise_reg <= 4'hf;
      rst_reg  <= 4'h0;
    end
    else
    begin
      fall_reg <= fall_next;
      low_reg  <= low_next;
      rise_reg <= rise_next;
      rst_reg  <= rst_next;
    end
  end
  // ****
  // Properties
  // ****
  sequence s_cs_idle;
    cs_n_i [*6];
  endsequence
  sequence s_rd_phase;
    hsel_i && htrans_i == 2'b10 && !hwrite_i;
  endsequence
  a_ready_always: assert property (hreadyout_o) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_o) else $error("hresp not okay");
  a_rdata_hold: assert property ($past(reset_n_i) && !$past(hsel_i && htrans_i == 2'b10
    && !hwrite_i) |-> $stable(hrdata_o)) else $error("hrdata moved");
  a_rdata_cover: cover property (s_rd_phase);
  a_oe_idle: assert property (s_cs_idle |-> so_oe_n_o) else $error("so driven idle");
  a_oe_start: assert property ($fell(so_oe_n_o) |-> low_reg > 8'hb4)
    else $error("data before address");
  a_so_edge: assert property (!so_oe_n_o && $past(!so_oe_n_o) && $changed(so_o)
    |-> fall_reg < 4'h8) else $error("so moved off edge");
  a_dpd_rise: assert property ($rose(deep_powerdown_o) |-> rst_reg < 4'h6)
    else $error("late power-down");
  a_dpd_wake: assert property ($fell(deep_powerdown_o) |-> rise_reg < 4'h8)
    else $error("wake without cs");
  a_dpd_quiet: assert property (deep_powerdown_o |-> so_oe_n_o)
    else $error("output in power-down");
endmodule
bind read_burst_wrap_addressing burst_wrap_chk u_burst_wrap_chk (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .so_o(so_o),
  .so_oe_n_o(so_oe_n_o), .deep_powerdown_o(deep_powerdown_o), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
`default_nettype wire

// ---- tb/serial_host.sv ----
/*
  Behavioural serial host: sends a 24-bit start address, clocks bytes out.
  Assumes the caller starts frames off the system clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host
(
  input  wire logic so_i,
  input  wire logic so_oe_n_i,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic si_o
);
  logic [7:0] got [0:63];
  int         oe_bad;
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
    oe_bad = 0;
  end
  // Clock stands low between frames
  task automatic frame(input logic [23:0] a, input int n);
    cs_n_o = 1'b0;
    #400;
    for (int i = 23; i >= 0; i--)
    begin
      si_o = a[i];
      #400 sclk_o = 1'b1;
      #400 sclk_o = 1'b0;
    end
    for (int b = 0; b < n; b++)
      for (int k = 7; k >= 0; k--)
      begin
        // Address done: si carries a toggling pattern
        si_o = ~si_o;
        #400 sclk_o = 1'b1;
        // Sample just before the fall that moves so
        #400 got[b][k] = so_i;
        oe_bad += so_oe_n_i;
        sclk_o = 1'b0;
      end
    // chip select pulse ends the burst
    #400 cs_n_o = 1'b1;
    #1000;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_read_burst_wrap_addressing.sv ----
/*
  Self-checking bench for the read burst wrap block.
  Assumes a 10 MHz mclk_i and the host model for the serial side.
*/
`timescale 1ns/1ps
`default_nettype none
module test_read_burst_wrap_addressing;
  import burst_wrap_pkg::*;
  logic        mclk_i;
  logic        reset_n_i;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hreadyout;
  logic        hresp;
  logic        so;
  logic        so_oe_n;
  logic        deep_powerdown;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic [23:0] last_addr;
  logic [7:0]  mem [0:255];
  int          fails;
  int          checks;
  int          seed;
  // Pull-up on the released data line
  wire logic   so_w = so_oe_n ? 1'b1 : so;
  read_burst_wrap_addressing u_read_burst_wrap_addressing (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_n_o(so_oe_n), .deep_powerdown_o(deep_powerdown), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .last_addr_o(last_addr));
  serial_host u_host (.so_i(so_w), .so_oe_n_i(so_oe_n), .sclk_o(sclk), .cs_n_o(cs_n),
    .si_o(si));
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // ****
  // Checking and bus tasks
  // ****
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk_i);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do begin @(posedge mclk_i); n++; end while (hreadyout !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge mclk_i); n++; end while (hreadyout !== 1'b1 && n < 64);
    r = hrdata;
    if (n >= 64)
    begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check("register", r, exp);
  endtask
  // Expected next byte address
  function automatic logic [23:0] step(input logic [23:0] a, input logic en,
                                       input logic [1:0] s);
    logic [23:0] m;
    m    = (24'h000008 << s) - 24'h000001;
    step = en ? ((a & ~m) | ((a + 24'h000001) & m)) : a + 24'h000001;
  endfunction
  task automatic burst(input logic en, input logic [1:0] s, input logic [23:0] a,
                       input int n);
    logic [23:0] x;
    logic [23:0] m;
    bus(1'b1, OFS_CFG_V, {27'h0000000, en, 2'b00, s});
    rdc(OFS_CFG_V, {27'h0000000, en, 2'b00, s});
    @(posedge mclk_i);
    #23;
    u_host.frame(a, n);
    x = a;
    m = (24'h000008 << s) - 24'h000001;
    for (int b = 0; b < n; b++)
    begin
      check("burst byte", {24'h000000, u_host.got[b]}, {24'h000000, mem[x[7:0]]});
      x = step(x, en, s);
    end
    if (en)
      check("wrap group", {8'h00, last_addr & ~m}, {8'h00, a & ~m});
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    seed      = 26102;
    fails     = 0;
    checks    = 0;
    reset_n_i = 1'b0;
    hsel      = 1'b0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    haddr     = 32'h00000000;
    hwdata    = 32'h00000000;
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    check("power pin", {31'h0, deep_powerdown}, 32'h00000000);
    rdc(OFS_STATUS, 32'h00000000);
    rdc(OFS_CFG_NV, {24'h000000, CFG_NV_RESET});
    rdc(OFS_CFG_V, {24'h000000, CFG_NV_RESET});
    rdc(8'h40, 32'h00000000);
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b1, OFS_CFG_NV, 32'h000000f7);
    rdc(OFS_CFG_NV, 32'h000000f7);
    // Power-down choice is a read-only copy in the volatile set
    bus(1'b1, OFS_CFG_V, 32'h000000ff);
    rdc(OFS_CFG_V, 32'h000000fb);
    for (int i = 0; i < 64; i++)
    begin
      r = $random(seed);
      {mem[4*i+3], mem[4*i+2], mem[4*i+1], mem[4*i]} = r;
      bus(1'b1, OFS_MEM_INDEX, i);
      bus(1'b1, OFS_MEM_DATA, {mem[4*i+3], mem[4*i+2], mem[4*i+1], mem[4*i]});
    end
    rdc(OFS_MEM_DATA, {mem[255], mem[254], mem[253], mem[252]});
    // Corner starts; wrap off with a large length selected
    burst(1'b0, WRAP_64, 24'h123403, 22);
    burst(1'b0, WRAP_8, 24'h0000fe, 6);
    burst(1'b1, WRAP_8, 24'h000007, 11);
    burst(1'b1, WRAP_16, 24'h00000c, 19);
    burst(1'b1, WRAP_32, 24'h00001e, 35);
    burst(1'b1, WRAP_64, 24'h00002e, 60);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      burst(r[31], r[30:29], r[23:0], 9 + r[27:24]);
    end
    // Mid-run reset keeps the nonvolatile copy, whose power-down bit is set
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    check("power pin", {31'h0, deep_powerdown}, 32'h00000001);
    rdc(OFS_STATUS, 32'h00000001);
    rdc(OFS_CFG_NV, 32'h000000f7);
    rdc(OFS_CFG_V, 32'h000000f7);
    // Frame in deep power-down is ignored; its chip select pulse wakes
    @(posedge mclk_i);
    #23;
    u_host.frame(24'h000000, 0);
    check("power pin", {31'h0, deep_powerdown}, 32'h00000000);
    rdc(OFS_STATUS, 32'h00000000);
    check("oe in burst", u_host.oe_bad, 32'h00000000);
    wrap_up();
  end
endmodule
`default_nettype wire
